// ==== logic/plmc_consts.svh ====
// constants of the programmable logic cell
`ifndef PLMC_CONSTS_SVH
`define PLMC_CONSTS_SVH
`define PLMC_NUM_PT 5
`define PLMC_MAX_CASCADE_PT 40
`define PLMC_NUM_CHAINS 8
`define PLMC_NUM_CELLS 128
`define PLMC_BLOCK_INPUTS 40
`define PLMC_REGION_CELLS 16
`define PLMC_FOLDBACK_MAX_PT 21
`define PLMC_NUM_GOE 6
`define PLMC_SIG_WIDTH 16
`define PLMC_GLOBAL_WIDTH 64
`define PLMC_SEL_W 6
`define PLMC_REG_RESET 1'b0
`endif

// ==== logic/plmc_pkg.sv ====
// types of the programmable logic cell
package plmc_pkg;
	typedef enum logic [1:0] {PLMC_XOR_PT = 2'h0, PLMC_XOR_HIGH = 2'h1, PLMC_XOR_LOW = 2'h2} plmc_xor_sel_t;
	typedef enum logic [1:0] {PLMC_D_XOR = 2'h0, PLMC_D_PT = 2'h1, PLMC_D_PIN = 2'h2} plmc_dsrc_t;
	typedef enum logic [2:0] {PLMC_FF_D = 3'h0, PLMC_FF_T = 3'h1, PLMC_FF_JK = 3'h2,
		PLMC_FF_SR = 3'h3, PLMC_FF_LATCH = 3'h4} plmc_ff_mode_t;
	typedef enum logic [1:0] {PLMC_CLR_GLOBAL = 2'h0, PLMC_CLR_PT = 2'h1, PLMC_CLR_OR = 2'h2,
		PLMC_CLR_OFF = 2'h3} plmc_clr_sel_t;
	typedef enum logic [1:0] {PLMC_OE_ON = 2'h0, PLMC_OE_OFF = 2'h1, PLMC_OE_GLOBAL = 2'h2} plmc_oe_mode_t;
	typedef struct packed {
		plmc_xor_sel_t xor_sel;
		plmc_dsrc_t data_src;
		plmc_ff_mode_t ff_mode;
		logic clk_from_pt;
		logic clk_en_used;
		plmc_clr_sel_t async_clear_select;
		logic async_preset_select;
		logic out_registered;
		logic fb_registered;
		plmc_oe_mode_t oe_mode;
		logic [2:0] oe_index;
		logic open_collector;
		logic [2:0] fold_pt;
	} plmc_cfg_t;
endpackage

// ==== logic/plmc_cell.sv ====
// one programmable logic cell with product terms, cascade, register and output logic
//
// Overview of operation
// R1: five product terms over global and regional buses
// R2: OR sums own terms plus cascade input
// R3: eight cascade chains reach forty terms
// R4: XOR second input: term, high, low
// R5: register data from XOR, term, pin
// R6: term data gives buried register, combinatorial pin
// R7: D, T, JK, SR modes via XOR
// R8: latch transparent on high clock, holds low
// R9: clock from global line or term, rising
// R10: clock enable term low ignores edges
// R11: clear from global, term, OR, or off
// R12: preset from term or off
// R13: output and feedback independently registered or combinatorial
// R14: enable on, off, or one of six
// R15: dedicated pins give clock, clear, enables
// R16: global bus feeds forty selected block inputs
// R17: inverted term to sixteen-cell regional bus
// R18: sixteen-bit signature always readable
// R19: open-collector mode for shared lines
// R20: registers cleared low at reset
// R21: selections are static configuration
`timescale 1ns/100ps
`include "plmc_consts.svh"
module plmc_cell
	import plmc_pkg::*;
#(
	parameter int GLOBAL_W = `PLMC_GLOBAL_WIDTH,
	parameter int BLOCK_IN = `PLMC_BLOCK_INPUTS,
	parameter int REGION_W = `PLMC_REGION_CELLS,
	parameter int NUM_PT = `PLMC_NUM_PT,
	parameter int NUM_GOE = `PLMC_NUM_GOE,
	parameter logic [`PLMC_SIG_WIDTH-1:0] SIGNATURE = 16'h0000
)
(
	input wire logic SYS_CLK_IN,
	input wire logic RESETN_IN,
	input wire plmc_cfg_t CFG_IN,
	input wire logic [GLOBAL_W-1:0] GLOBAL_BUS_IN,
	input wire logic [BLOCK_IN*`PLMC_SEL_W-1:0] MATRIX_SEL_IN,
	input wire logic [REGION_W-1:0] REGION_BUS_IN,
	input wire logic [NUM_PT*(BLOCK_IN+REGION_W)-1:0] PT_TRUE_IN,
	input wire logic [NUM_PT*(BLOCK_IN+REGION_W)-1:0] PT_COMP_IN,
	input wire logic [NUM_PT-1:0] PT_TO_OR_IN,
	input wire logic CASCADE_INPUT_IN,
	input wire logic GLOBAL_CLOCK_LINE_IN,
	input wire logic GLOBAL_CLEAR_LINE_IN,
	input wire logic [NUM_GOE-1:0] GLOBAL_OE_IN,
	input wire logic PIN_IN,
	output logic PIN_OUT,
	output logic PIN_OE_OUT,
	output logic FEEDBACK_OUT,
	output logic FOLDBACK_OUT,
	output logic CASCADE_OUT,
	output logic [`PLMC_SIG_WIDTH-1:0] SIGNATURE_OUT
);
	localparam int AW = BLOCK_IN + REGION_W;
	logic [BLOCK_IN-1:0] block_in;
	logic [AW-1:0] array_in;
	logic [NUM_PT-1:0] pt;
	logic or_sum, xor_b, xor_out, d_in, next_q, ctl_en, reg_clk, clr, pre;
	logic pin_s1_q, pin_s2_q, pin_s3_q, pin_sync_q;
	logic gclk_s1_q, gclk_s2_q, gclk_s3_q, gclk_prev_q, gclr_s1_q, gclr_s2_q, gclr_s3_q;
	logic gclk_q, gclr_q, gclk_rise, pt_clk_prev_q, pt_rise, edge_hit;
	logic state_q, comb_out, out_val;
	// switch matrix picks block inputs from the global bus
	genvar gi;
	generate
		for (gi = 0; gi < BLOCK_IN; gi++)
		begin : g_mux
			assign block_in[gi] = GLOBAL_BUS_IN[MATRIX_SEL_IN[gi*`PLMC_SEL_W +: `PLMC_SEL_W]]; // R16
		end
		for (gi = 0; gi < NUM_PT; gi++)
		begin : g_pt
			// unused literal (both masks zero) keeps the term true
			assign pt[gi] = &((array_in | ~PT_TRUE_IN[gi*AW +: AW]) &
				(~array_in | ~PT_COMP_IN[gi*AW +: AW])); // R1
		end
	endgenerate
	assign array_in = {REGION_BUS_IN, block_in}; // R1
	// term 0 goes to xor, 1 data, 2 clock/enable, 3 clear, 4 preset, whether summed or not
	assign or_sum = |(pt & PT_TO_OR_IN) | CASCADE_INPUT_IN; // R2 R3
	assign CASCADE_OUT = or_sum; // R3
	always_comb
	begin
		unique case (CFG_IN.xor_sel) // R4
			PLMC_XOR_PT: xor_b = pt[0];
			PLMC_XOR_HIGH: xor_b = 1'b1;
			default: xor_b = 1'b0;
		endcase
	end
	assign xor_out = or_sum ^ xor_b; // R4 R7
	// the pin, global clock and global clear lines pass three stages; second and third must agree
	// the agreement filter drops a one-sample glitch at the cost of one cycle
	always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN)
	begin
		if (!RESETN_IN)
		begin
			{pin_s1_q, pin_s2_q, pin_s3_q} <= 3'h0;
			pin_sync_q <= 1'b0;
		end
		else
		begin
			{pin_s3_q, pin_s2_q, pin_s1_q} <= {pin_s2_q, pin_s1_q, PIN_IN};
			if (pin_s2_q == pin_s3_q)
				pin_sync_q <= pin_s3_q; // R5
		end
	end
	always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN)
	begin
		if (!RESETN_IN)
		begin
			{gclk_s1_q, gclk_s2_q, gclk_s3_q} <= 3'h0;
			gclk_q <= 1'b0;
		end
		else
		begin
			{gclk_s3_q, gclk_s2_q, gclk_s1_q} <= {gclk_s2_q, gclk_s1_q, GLOBAL_CLOCK_LINE_IN};
			if (gclk_s2_q == gclk_s3_q)
				gclk_q <= gclk_s3_q; // R15
		end
	end
	always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN)
	begin
		if (!RESETN_IN)
		begin
			{gclr_s1_q, gclr_s2_q, gclr_s3_q} <= 3'h0;
			gclr_q <= 1'b0;
		end
		else
		begin
			{gclr_s3_q, gclr_s2_q, gclr_s1_q} <= {gclr_s2_q, gclr_s1_q, GLOBAL_CLEAR_LINE_IN};
			if (gclr_s2_q == gclr_s3_q)
				gclr_q <= gclr_s3_q; // R15
		end
	end
	always_comb
	begin
		unique case (CFG_IN.data_src) // R5 R6
			PLMC_D_PT: d_in = pt[1];
			PLMC_D_PIN: d_in = pin_sync_q;
			default: d_in = xor_out;
		endcase
	end
	assign reg_clk = CFG_IN.clk_from_pt ? pt[2] : gclk_q; // R9
	assign ctl_en = CFG_IN.clk_from_pt | ~CFG_IN.clk_en_used | pt[2]; // R10
	always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN)
	begin
		if (!RESETN_IN)
		begin
			gclk_prev_q <= 1'b0;
			pt_clk_prev_q <= 1'b0;
		end
		else
		begin
			gclk_prev_q <= gclk_q;
			pt_clk_prev_q <= pt[2];
		end
	end
	assign gclk_rise = gclk_q & ~gclk_prev_q;
	assign pt_rise = pt[2] & ~pt_clk_prev_q;
	// the clock enable shares term 2, so it only applies with the global clock
	assign edge_hit = CFG_IN.clk_from_pt ? pt_rise : (gclk_rise & ctl_en); // R9 R10
	always_comb
	begin
		unique case (CFG_IN.async_clear_select) // R11
			PLMC_CLR_GLOBAL: clr = gclr_q;
			PLMC_CLR_PT: clr = pt[3];
			PLMC_CLR_OR: clr = gclr_q | pt[3];
			PLMC_CLR_OFF: clr = 1'b0;
		endcase
	end
	assign pre = CFG_IN.async_preset_select & pt[4]; // R12
	always_comb
	begin
		unique case (CFG_IN.ff_mode) // R7
			PLMC_FF_T: next_q = state_q ^ d_in;
			PLMC_FF_JK: next_q = (d_in & ~state_q) | (~pt[0] & state_q);
			PLMC_FF_SR: next_q = d_in | (state_q & ~pt[0]);
			default: next_q = d_in;
		endcase
	end
	// clear and preset act at once in the sampled domain; clear wins over preset
	always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN)
	begin
		if (!RESETN_IN)
			state_q <= `PLMC_REG_RESET; // R20
		else if (clr)
			state_q <= 1'b0; // R11
		else if (pre)
			state_q <= 1'b1; // R12
		else if (CFG_IN.ff_mode == PLMC_FF_LATCH)
		begin
			if (reg_clk)
				state_q <= d_in; // R8
		end
		else if (edge_hit)
			state_q <= next_q; // R9 R10
	end
	assign comb_out = xor_out;
	assign out_val = CFG_IN.out_registered ? state_q : comb_out; // R13 R6
	assign FEEDBACK_OUT = CFG_IN.fb_registered ? state_q : comb_out; // R13 R6
	assign FOLDBACK_OUT = ~pt[CFG_IN.fold_pt]; // R17
	logic oe_sel;
	always_comb
	begin
		unique case (CFG_IN.oe_mode) // R14
			PLMC_OE_ON: oe_sel = 1'b1;
			PLMC_OE_GLOBAL: oe_sel = GLOBAL_OE_IN[CFG_IN.oe_index]; // R15
			default: oe_sel = 1'b0;
		endcase
	end
	// open collector drives low only; high is left to the shared pull-up
	assign PIN_OUT = CFG_IN.open_collector ? 1'b0 : out_val; // R19
	assign PIN_OE_OUT = oe_sel & (~CFG_IN.open_collector | ~out_val); // R14 R19
	assign SIGNATURE_OUT = SIGNATURE; // R18
	// configuration is expected static; no assertion polices it here (R21)
	checked_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RESETN_IN)
		clr |=> !state_q) else $error("clear did not force low"); // R11
	preset_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RESETN_IN)
		pre && !clr |=> state_q) else $error("preset did not force high"); // R12
	hold_en_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RESETN_IN)
		!clr && !pre && CFG_IN.ff_mode != PLMC_FF_LATCH && !edge_hit |=> $stable(state_q))
		else $error("register moved without edge"); // R10
	d_edge_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RESETN_IN)
		!clr && !pre && CFG_IN.ff_mode == PLMC_FF_D && edge_hit |=> state_q == $past(d_in))
		else $error("d register missed data"); // R9
	latch_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RESETN_IN)
		!clr && !pre && CFG_IN.ff_mode == PLMC_FF_LATCH && !reg_clk |=> $stable(state_q))
		else $error("latch moved while closed"); // R8
	oe_off_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RESETN_IN)
		CFG_IN.oe_mode == PLMC_OE_OFF |-> !PIN_OE_OUT) else $error("buffer on while off"); // R14
	oc_high_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RESETN_IN)
		CFG_IN.open_collector && out_val |-> !PIN_OE_OUT) else $error("open collector drove high"); // R19
	fold_inv_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RESETN_IN)
		FOLDBACK_OUT != pt[CFG_IN.fold_pt]) else $error("foldback not inverted"); // R17
	sig_a: assert property (@(posedge SYS_CLK_IN) SIGNATURE_OUT == SIGNATURE)
		else $error("signature lost"); // R18
	cas_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RESETN_IN)
		CASCADE_INPUT_IN |-> CASCADE_OUT) else $error("cascade input not summed"); // R2
	// per-mode checks state the expected outcome; only the toggle check repeats the next-state expression
	t_edge_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RESETN_IN) // R7
		!clr && !pre && CFG_IN.ff_mode == PLMC_FF_T && edge_hit |=>
		state_q == ($past(state_q) ^ $past(d_in))) else $error("toggle register wrong");
	jk_set_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RESETN_IN) // R7
		!clr && !pre && CFG_IN.ff_mode == PLMC_FF_JK && edge_hit && d_in && !pt[0] |=> state_q)
		else $error("jk register did not set");
	jk_clr_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RESETN_IN) // R7
		!clr && !pre && CFG_IN.ff_mode == PLMC_FF_JK && edge_hit && !d_in && pt[0] |=> !state_q)
		else $error("jk register did not reset");
	sr_set_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RESETN_IN) // R7
		!clr && !pre && CFG_IN.ff_mode == PLMC_FF_SR && edge_hit && d_in |=> state_q)
		else $error("sr register did not set");
	latch_open_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RESETN_IN) // R8
		!clr && !pre && CFG_IN.ff_mode == PLMC_FF_LATCH && reg_clk |=> state_q == $past(d_in))
		else $error("open latch did not pass data");
	en_low_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RESETN_IN) // R10
		!clr && !pre && !CFG_IN.clk_from_pt && CFG_IN.clk_en_used && !pt[2] &&
		CFG_IN.ff_mode != PLMC_FF_LATCH |=> $stable(state_q)) else $error("edge taken with enable low");
	en_high_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RESETN_IN) // R10
		!clr && !pre && !CFG_IN.clk_from_pt && pt[2] && gclk_rise &&
		CFG_IN.ff_mode == PLMC_FF_D |=> state_q == $past(d_in)) else $error("enabled edge lost");
	// the enable checks below exclude open collector, where the buffer also turns off on a high output
	oe_on_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RESETN_IN) // R14
		CFG_IN.oe_mode == PLMC_OE_ON && !CFG_IN.open_collector |-> PIN_OE_OUT) else $error("buffer off");
	goe_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RESETN_IN) // R14
		CFG_IN.oe_mode == PLMC_OE_GLOBAL && !CFG_IN.open_collector |->
		PIN_OE_OUT == GLOBAL_OE_IN[CFG_IN.oe_index]) else $error("global enable not followed");
	out_sel_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RESETN_IN) // R13
		!CFG_IN.out_registered && !CFG_IN.open_collector |-> PIN_OUT == xor_out)
		else $error("combinatorial output wrong");
	fb_reg_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RESETN_IN) // R13
		CFG_IN.fb_registered |-> FEEDBACK_OUT == state_q) else $error("feedback not registered");
	polarity_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RESETN_IN) // R4
		CFG_IN.xor_sel == PLMC_XOR_HIGH |-> xor_out == !or_sum) else $error("polarity not inverted");
	xor_low_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RESETN_IN) // R4
		CFG_IN.xor_sel == PLMC_XOR_LOW |-> xor_out == or_sum) else $error("polarity not kept");
	dsrc_pin_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RESETN_IN) // R5
		CFG_IN.data_src == PLMC_D_PIN |-> d_in == pin_sync_q) else $error("pin data not chosen");
	d_pt_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RESETN_IN) // R6
		CFG_IN.data_src == PLMC_D_PT |-> d_in == pt[1]) else $error("term data not chosen");
	or_sum_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RESETN_IN) // R2
		|(pt & PT_TO_OR_IN) |-> CASCADE_OUT) else $error("own term not summed");
	reset_low_a: assert property (@(posedge SYS_CLK_IN) // R20
		$rose(RESETN_IN) |-> !state_q) else $error("register not low after reset");
	oc_low_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RESETN_IN) // R19
		CFG_IN.open_collector && !out_val && oe_sel |-> PIN_OE_OUT && !PIN_OUT)
		else $error("open collector did not pull low");
	clr_or_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RESETN_IN) // R11
		CFG_IN.async_clear_select == PLMC_CLR_OR && gclr_q |-> clr) else $error("global clear lost");
	clr_off_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RESETN_IN) // R11
		CFG_IN.async_clear_select == PLMC_CLR_OFF |-> !clr) else $error("clear active while off");
	pre_off_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RESETN_IN) // R12
		!CFG_IN.async_preset_select |-> !pre) else $error("preset active while off");
	clk_edge_c: cover property (@(posedge SYS_CLK_IN) disable iff (!RESETN_IN) edge_hit);
	jk_c: cover property (@(posedge SYS_CLK_IN) disable iff (!RESETN_IN)
		CFG_IN.ff_mode == PLMC_FF_JK && edge_hit);
	latch_c: cover property (@(posedge SYS_CLK_IN) disable iff (!RESETN_IN)
		CFG_IN.ff_mode == PLMC_FF_LATCH && reg_clk);
	clr_c: cover property (@(posedge SYS_CLK_IN) disable iff (!RESETN_IN) clr && state_q);
	buried_c: cover property (@(posedge SYS_CLK_IN) disable iff (!RESETN_IN)
		CFG_IN.data_src == PLMC_D_PT && !CFG_IN.out_registered && edge_hit);
endmodule

// ==== test/plmc_board.sv ====
// board-side model: drives the dedicated clock pin, still while idle
`timescale 1ns/100ps
module plmc_board
(
	input wire logic clk_in,
	input wire logic resetn_in,
	input wire logic run_in,
	output logic gclk_out
);
	logic [2:0] div_q;
	always_ff @(posedge clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			div_q <= 3'h0;
			gclk_out <= 1'b0;
		end
		else
		begin
			div_q <= run_in ? div_q + 3'h1 : 3'h0;
			gclk_out <= run_in & (div_q == 3'h7 ? ~gclk_out : gclk_out);
		end
	end
endmodule

// ==== test/tb.sv ====
// self-checking bench for one logic cell
`timescale 1ns/100ps
module tb;
	import plmc_pkg::*;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	plmc_cfg_t cfg = '0;
	plmc_cfg_t c;
	logic [63:0] g = 64'h0;
	logic [239:0] msel;
	logic [15:0] rb = 16'h0;
	logic [279:0] ptt;
	logic [279:0] ptc = '0;
	logic casc = 1'b0;
	logic [4:0] tor = 5'h01;
	logic gclr = 1'b0;
	logic [5:0] goe = 6'h00;
	logic pin_in = 1'b0;
	logic run = 1'b0;
	logic gclk, po, poe, fb, fold, co;
	logic [15:0] sig;
	int failures = 0;
	int total_checks = 0;
	plmc_cell #(.SIGNATURE(16'hA5C3)) plmc_cell_i (.SYS_CLK_IN(clk), .RESETN_IN(rstn),
		.CFG_IN(cfg), .GLOBAL_BUS_IN(g), .MATRIX_SEL_IN(msel), .REGION_BUS_IN(rb),
		.PT_TRUE_IN(ptt), .PT_COMP_IN(ptc), .PT_TO_OR_IN(tor), .CASCADE_INPUT_IN(casc),
		.GLOBAL_CLOCK_LINE_IN(gclk), .GLOBAL_CLEAR_LINE_IN(gclr), .GLOBAL_OE_IN(goe),
		.PIN_IN(pin_in), .PIN_OUT(po), .PIN_OE_OUT(poe), .FEEDBACK_OUT(fb),
		.FOLDBACK_OUT(fold), .CASCADE_OUT(co), .SIGNATURE_OUT(sig));
	plmc_board plmc_board_i (.clk_in(clk), .resetn_in(rstn), .run_in(run), .gclk_out(gclk));
	initial
	begin
		forever #2 clk = ~clk;
	end
	task automatic check(input string n, input logic [15:0] s, input logic [15:0] e);
		total_checks++;
		if (s !== e)
		begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic end_sim();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// configuration may only change while the cell is held in reset
	task automatic setup();
		@(posedge clk);
		rstn <= 1'b0;
		cfg <= c;
		g <= 64'h0;
		cyc(3);
		rstn <= 1'b1;
		cyc(1);
	endtask
	task automatic drv(input int b, input logic v);
		@(posedge clk);
		g[b] <= v;
		cyc(2);
	endtask
	// bounded wait; the global lines pass a three-stage synchroniser and the board clock toggles every eighth cycle
	task automatic wait_po(input logic e);
		int n;
		n = 0;
		while (po !== e && n < 40)
		begin
			cyc(1);
			n++;
		end
		if (po !== e)
		begin
			check("pin wait", po, e);
			end_sim();
		end
	endtask
	initial
	begin
		for (int k = 0; k < 40; k++)
			msel[k*6 +: 6] = 6'(k);
		ptt = '0;
		for (int i = 0; i < 5; i++)
			ptt[i*56+i] = 1'b1;
		c = '0;
		c.fold_pt = 3'h1;
		for (int m = 0; m < 3; m++)
		begin
			c.xor_sel = plmc_xor_sel_t'(m);
			setup();
			drv(0, 1'b1);
			check("xor", po, m == 2);
			check("or", co, 1'b1);
			check("fold", fold, 1'b1);
			check("oe on", poe, 1'b1);
		end
		$display("test polarity done");
		c.xor_sel = PLMC_XOR_LOW;
		c.data_src = PLMC_D_PT;
		c.clk_from_pt = 1'b1;
		c.async_clear_select = PLMC_CLR_PT;
		c.async_preset_select = 1'b1;
		c.fb_registered = 1'b1;
		setup();
		check("reset", fb, 1'b0);
		drv(1, 1'b1);
		drv(0, 1'b1);
		check("comb out", po, 1'b1);
		check("buried", fb, 1'b0);
		drv(2, 1'b1);
		check("ff d", fb, 1'b1);
		drv(3, 1'b1);
		check("clear", fb, 1'b0);
		drv(3, 1'b0);
		drv(4, 1'b1);
		check("preset", fb, 1'b1);
		$display("test register done");
		c.ff_mode = PLMC_FF_T;
		c.out_registered = 1'b1;
		setup();
		drv(1, 1'b1);
		for (int t = 1; t < 4; t++)
		begin
			drv(2, 1'b1);
			check("toggle", po, t % 2);
			drv(2, 1'b0);
		end
		$display("test toggle done");
		c.ff_mode = PLMC_FF_D;
		c.clk_from_pt = 1'b0;
		c.clk_en_used = 1'b1;
		c.async_clear_select = PLMC_CLR_GLOBAL;
		c.oe_mode = PLMC_OE_GLOBAL;
		c.oe_index = 3'h3;
		setup();
		drv(1, 1'b1);
		run <= 1'b1;
		cyc(40);
		check("enable low", po, 1'b0);
		check("goe off", poe, 1'b0);
		goe <= 6'h08;
		drv(2, 1'b1);
		check("goe on", poe, 1'b1);
		wait_po(1'b1);
		run <= 1'b0;
		gclr <= 1'b1;
		wait_po(1'b0);
		gclr <= 1'b0;
		$display("test global done");
		c = '0;
		c.ff_mode = PLMC_FF_LATCH;
		c.clk_from_pt = 1'b1;
		c.data_src = PLMC_D_PIN;
		c.fb_registered = 1'b1;
		c.async_clear_select = PLMC_CLR_OFF;
		setup();
		pin_in <= 1'b1;
		cyc(6);
		check("latch shut", fb, 1'b0);
		drv(2, 1'b1);
		check("latch open", fb, 1'b1);
		drv(2, 1'b0);
		pin_in <= 1'b0;
		gclr <= 1'b1;
		cyc(6);
		check("latch hold", fb, 1'b1);
		gclr <= 1'b0;
		$display("test latch done");
		c.ff_mode = PLMC_FF_JK;
		c.data_src = PLMC_D_PT;
		c.async_clear_select = PLMC_CLR_OR;
		setup();
		drv(1, 1'b1);
		drv(2, 1'b1);
		check("jk set", fb, 1'b1);
		drv(2, 1'b0);
		drv(1, 1'b0);
		drv(0, 1'b1);
		drv(2, 1'b1);
		check("jk reset", fb, 1'b0);
		drv(2, 1'b0);
		drv(0, 1'b0);
		drv(1, 1'b1);
		drv(2, 1'b1);
		check("jk set again", fb, 1'b1);
		gclr <= 1'b1;
		cyc(6);
		check("clear or", fb, 1'b0);
		gclr <= 1'b0;
		cyc(6);
		$display("test jk done");
		c = '0;
		c.open_collector = 1'b1;
		c.xor_sel = PLMC_XOR_LOW;
		setup();
		check("oc low", {po, poe}, 2'h1);
		drv(0, 1'b1);
		check("oc high", poe, 1'b0);
		check("sig", sig, 16'hA5C3);
		tor <= 5'h00;
		cyc(1);
		check("or mask", co, 1'b0);
		casc <= 1'b1;
		cyc(1);
		check("cascade", co, 1'b1);
		$display("test misc done");
		end_sim();
	end
endmodule
